// ### rtl/led_level_ctrl.sv
/*
  Level and configuration logic of a dimmable LED driver: programmed
  settings with apply-on-power-cycle (temperature word live), current setpoint, temperature
  derating, lumen depreciation compensation, DC emergency dimming and
  corridor mode. Assumes mains_cycle is a one-clock pulse from the power
  monitor, and that control and DC detect pins are asynchronous.
*/
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module led_level_ctrl
#(
  parameter int TICK_CYCLES = led_cfg_pkg::TICK_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mains_cycle,
  input  wire logic        lamp_on,
  input  wire logic        ctrl_mains_in,
  input  wire logic        dc_mains_in,
  input  wire logic        dali_mode,
  input  wire logic [7:0]  module_temp,
  input  wire logic [7:0]  dim_level,
  input  wire logic        dali_override,
  output logic [15:0]      current_target,
  output logic             phys_min,
  output logic             output_off,
  output logic             corridor_active
);
  import led_cfg_pkg::*;

  logic [31:0] cfg_r [N_CFG];
  logic [31:0] act_r [N_CFG];
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        do_write;
  logic        apply;
  logic        lamp_on_d_r;
  logic [2:0]  ctrl_sync_r;
  logic [2:0]  dc_sync_r;
  logic        ctrl_r;
  logic        dc_r;
  logic [27:0] tick_cnt_r;
  logic        tick_r;
  logic [11:0] hsec_r;
  logic [9:0]  hr_r;
  logic [6:0]  kh_r;
  corridor_e   cor_r;
  logic [11:0] cor_cnt_r;
  logic [7:0]  cor_lvl;
  logic [15:0] current_r;
  logic        phys_min_r;
  logic        off_r;

  // True when the byte address names a configuration word
  function automatic logic is_cfg(input logic [7:0] a);
    return (a[7:6] == 2'b00) && (a[1:0] == 2'b00);
  endfunction : is_cfg

  // Byte field of a word
  function automatic logic [7:0] fld8(input logic [31:0] w, input int lsb);
    return w[lsb +: 8];
  endfunction : fld8

  // Write channel ready while no address/data held and no reply pending
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign do_write      = aw_have_r && w_have_r;

  // Capture write address and data in either order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (do_write)
        aw_have_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (do_write)
        w_have_r <= 1'b0;
    end
  end

  // Write reply; group writes need no readback from the block
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= 2'b00;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= (is_cfg(aw_addr_r) || aw_addr_r == A_STATUS || aw_addr_r == A_CURRENT
                   || aw_addr_r == A_HOURS) ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Read reply one cycle after the address is taken
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= 2'b00;
      if (is_cfg(s_axi_araddr))
        rdata_r <= cfg_r[s_axi_araddr[5:2]];
      else if (s_axi_araddr == A_STATUS)
        rdata_r <= {21'h0_0000, off_r, phys_min_r, corridor_active, cor_lvl};
      else if (s_axi_araddr == A_CURRENT)
        rdata_r <= {16'h0000, current_r};
      else if (s_axi_araddr == A_HOURS)
        rdata_r <= {15'h0000, kh_r, hr_r};
      else
      begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= 2'b10;
      end
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // Apply pending settings on mains cycle or standby off-then-on
  assign apply = mains_cycle
               || (act_r[IDX_CTRL][B_MIN1PCT] && lamp_on && !lamp_on_d_r);

  always_ff @(posedge clk)
  begin
    if (rst)
      lamp_on_d_r <= 1'b1; // Lamp idles on, so no false edge after reset
    else
      lamp_on_d_r <= lamp_on;
  end

  // Programmed words survive mains cycles; active copies load on apply
  for (genvar i = 0; i < N_CFG; i++)
  begin : g_cfg
    localparam logic [31:0] RV = (i == IDX_CTRL)  ? RST_CTRL  :
                                 (i == IDX_SETPT) ? RST_SETPT :
                                 (i == IDX_TEMP)  ? RST_TEMP  :
                                 (i == IDX_EMG)   ? RST_EMG   :
                                 (i == IDX_CORA)  ? RST_CORA  :
                                 (i == IDX_CORB)  ? RST_CORB  :
                                 (i == IDX_ACT)   ? RST_ACT   :
                                 (i >= IDX_PROF)  ? RST_PROF  : 32'h0000_0000;
    always_ff @(posedge clk)
    begin
      if (rst)
        cfg_r[i] <= RV;
      else if (do_write && is_cfg(aw_addr_r) && aw_addr_r[5:2] == 4'(i))
      begin
        for (int b = 0; b < 4; b++)
          if (w_strb_r[b])
            cfg_r[i][8*b +: 8] <= w_data_r[8*b +: 8];
      end
    end
    always_ff @(posedge clk)
    begin
      if (rst)
        act_r[i] <= RV;
      else if (apply)
        act_r[i] <= cfg_r[i];
    end
  end

  // Three-stage synchronisers for the mains-derived pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_sync_r <= 3'b000;
      dc_sync_r   <= 3'b000;
      ctrl_r      <= 1'b0;
      dc_r        <= 1'b0;
    end
    else
    begin
      ctrl_sync_r <= {ctrl_sync_r[1:0], ctrl_mains_in};
      dc_sync_r   <= {dc_sync_r[1:0], dc_mains_in};
      if (ctrl_sync_r[1] == ctrl_sync_r[2])
        ctrl_r <= ctrl_sync_r[2];
      if (dc_sync_r[1] == dc_sync_r[2])
        dc_r <= dc_sync_r[2];
    end
  end

  // Common one-second tick
  always_ff @(posedge clk)
  begin
    if (rst || tick_cnt_r == 28'(TICK_CYCLES - 1))
      tick_cnt_r <= 28'h0000000;
    else
      tick_cnt_r <= tick_cnt_r + 28'h0000001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tick_r <= 1'b0;
    else
      tick_r <= (tick_cnt_r == 28'(TICK_CYCLES - 1));
  end

  // Working hours while light is on, kept in thousands plus remainder
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hsec_r <= 12'h000;
      hr_r   <= 10'h000;
      kh_r   <= 7'h00;
    end
    else if (tick_r && !off_r)
    begin
      if (hsec_r == SEC_PER_HOUR - 12'd1)
      begin
        hsec_r <= 12'h000;
        if (hr_r == HOURS_PER_KH - 10'd1)
        begin
          hr_r <= 10'h000;
          if (kh_r != 7'h7f)
            kh_r <= kh_r + 7'h01;
        end
        else
          hr_r <= hr_r + 10'h001;
      end
      else
        hsec_r <= hsec_r + 12'h001;
    end
  end

  // Corridor mode sequencer
  always_ff @(posedge clk)
  begin
    if (rst || mains_cycle)
    begin
      cor_r     <= CR_TD;
      cor_cnt_r <= 12'h000;
    end
    else
    begin
      case (cor_r)
        CR_TD:
          if (dali_mode || !ctrl_r)
            cor_cnt_r <= 12'h000;
          else if (cor_cnt_r >= act_r[IDX_ACT][11:0] && cor_cnt_r != 12'h000)
          begin
            cor_r     <= CR_NORMAL;
            cor_cnt_r <= 12'h000;
          end
          else if (tick_r)
            cor_cnt_r <= cor_cnt_r + 12'h001;
        CR_NORMAL:
          if (!ctrl_r)
          begin
            cor_r     <= CR_DELAY;
            cor_cnt_r <= 12'h000;
          end
        default:
          if (ctrl_r)
          begin
            cor_r     <= CR_NORMAL;
            cor_cnt_r <= 12'h000;
          end
          else if (cor_r == CR_DELAY && cor_cnt_r >= act_r[IDX_CORB][11:0])
          begin
            cor_r     <= CR_FADE;
            cor_cnt_r <= 12'h000;
          end
          else if (cor_r == CR_FADE
                   && cor_cnt_r >= {5'h00, fade_secs(act_r[IDX_CORA][F_BYTE2 +: 4])})
          begin
            cor_r     <= CR_BACK;
            cor_cnt_r <= 12'h000;
          end
          else if (cor_r == CR_BACK && act_r[IDX_CORB][F_PROLONG +: 12] != PROLONG_INF
                   && cor_cnt_r >= act_r[IDX_CORB][F_PROLONG +: 12])
          begin
            cor_r     <= CR_OFF;
            cor_cnt_r <= 12'h000;
          end
          else if (tick_r && cor_r != CR_OFF)
            cor_cnt_r <= cor_cnt_r + 12'h001;
      endcase
    end
  end

  assign corridor_active = (cor_r != CR_TD);

  // Corridor level, faded linearly between normal and background
  always_comb
  begin
    logic [7:0]  n;
    logic [7:0]  g;
    logic [6:0]  fs;
    logic [15:0] step;
    n    = fld8(act_r[IDX_CORA], F_BYTE0);
    g    = fld8(act_r[IDX_CORA], F_BYTE1);
    fs   = fade_secs(act_r[IDX_CORA][F_BYTE2 +: 4]);
    step = 16'h0000;
    cor_lvl = n;
    case (cor_r)
      CR_FADE:
      begin
        if (fs != 7'h00)
          step = ((n >= g ? 16'(n - g) : 16'(g - n)) * cor_cnt_r[7:0]) / 16'(fs);
        cor_lvl = (n >= g) ? n - step[7:0] : n + step[7:0];
      end
      CR_BACK:  cor_lvl = g;
      CR_OFF:   cor_lvl = 8'h00;
      default:  cor_lvl = n;
    endcase
  end

  // Target current from setpoint, compensation, level and derating
  always_comb
  begin
    logic [15:0] base;
    logic [6:0]  cpct;
    logic [6:0]  tpct;
    logic [7:0]  lvl;
    logic [7:0]  ts;
    logic [7:0]  tp;
    logic [7:0]  to;
    logic [6:0]  tm;
    logic [39:0] acc;
    base = act_r[IDX_CTRL][B_SETPT_EN] ? act_r[IDX_SETPT][15:0] : RST_SETPT[15:0];
    cpct = PCT_FULL;
    tpct = PCT_FULL;
    if (act_r[IDX_CTRL][B_COMP_EN])
    begin
      for (int k = 0; k < N_PROF; k++)
        if (act_r[IDX_PROF + k][F_BYTE1 +: 7] <= kh_r)
          cpct = (act_r[IDX_PROF + k][6:0] > PCT_FULL) ? PCT_FULL
                 : act_r[IDX_PROF + k][6:0];
    end
    lvl = corridor_active ? cor_lvl : dim_level;
    if (act_r[IDX_CTRL][B_EMG_EN] && dc_r)
    begin
      if (act_r[IDX_CTRL][B_EMG_ALLOW] && dali_override)
        lvl = dim_level;
      else if (fld8(act_r[IDX_EMG], F_BYTE0) != LVL_KEEP)
        lvl = fld8(act_r[IDX_EMG], F_BYTE0);
    end
    ts = fld8(cfg_r[IDX_TEMP], F_BYTE0);
    tp = fld8(cfg_r[IDX_TEMP], F_BYTE1);
    to = fld8(cfg_r[IDX_TEMP], F_BYTE2);
    tm = cfg_r[IDX_TEMP][F_BYTE3 +: 7];
    if (module_temp <= ts)
      tpct = PCT_FULL;
    else if (module_temp >= tp)
      tpct = tm;
    else
      tpct = 7'(PCT_FULL - 7'((16'(PCT_FULL - tm) * 16'(module_temp - ts))
                              / 16'(tp - ts)));
    acc = 40'(base) * 40'(cpct);
    acc = (acc * 40'(PCT_DIV_MUL)) >> PCT_DIV_SHIFT;
    acc = (acc * 40'(tpct) * 40'(PCT_DIV_MUL)) >> PCT_DIV_SHIFT;
    acc = (lvl >= LVL_MAX) ? acc : (acc * 40'(lvl)) >> LVL_SHIFT;
    current_r = acc[15:0];
    phys_min_r = (module_temp >= to);
    off_r = (cpct == 7'h00) || (lvl == 8'h00);
  end

  // Registered outputs toward the power stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      current_target <= 16'h0000;
      phys_min       <= 1'b0;
      output_off     <= 1'b1;
    end
    else
    begin
      current_target <= phys_min_r ? PHYS_MIN_MA : (off_r ? 16'h0000 : current_r);
      phys_min       <= phys_min_r;
      output_off     <= off_r && !phys_min_r;
    end
  end

endmodule : led_level_ctrl

// ### rtl/led_cfg_pkg.sv
/*
  Constants, register map, defaults and corridor states of the LED driver
  level and configuration logic. Assumes a 250 MHz clock and a 32-bit
  AXI4-Lite register port with byte addresses below 0x100.
*/
package led_cfg_pkg;

  // Timebase
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;
  localparam logic [11:0] SEC_PER_HOUR = 12'd3600;
  localparam logic [9:0]  HOURS_PER_KH = 10'd1000;

  // Configuration words: index i sits at byte address 4*i
  localparam int N_CFG     = 16;
  localparam int N_PROF    = 8;
  localparam int IDX_CTRL  = 0;
  localparam int IDX_SETPT = 1;
  localparam int IDX_TEMP  = 2;
  localparam int IDX_EMG   = 3;
  localparam int IDX_CORA  = 4;
  localparam int IDX_CORB  = 5;
  localparam int IDX_ACT   = 6;
  localparam int IDX_PROF  = 8;
  localparam logic [7:0] A_STATUS  = 8'h40;
  localparam logic [7:0] A_CURRENT = 8'h44;
  localparam logic [7:0] A_HOURS   = 8'h48;

  // Control word bits
  localparam int B_SETPT_EN  = 0;
  localparam int B_COMP_EN   = 1;
  localparam int B_EMG_EN    = 2;
  localparam int B_EMG_ALLOW = 3;
  localparam int B_MIN1PCT   = 4;

  // Field positions (byte lanes, plus the prolong field at bit 12)
  localparam int F_BYTE0 = 0;
  localparam int F_BYTE1 = 8;
  localparam int F_BYTE2 = 16;
  localparam int F_BYTE3 = 24;
  localparam int F_PROLONG = 12;

  // Limits and special values
  localparam logic [6:0]  PCT_FULL      = 7'd100;
  localparam logic [7:0]  LVL_KEEP      = 8'hff;
  localparam logic [7:0]  LVL_MAX       = 8'hfe;
  localparam logic [11:0] PROLONG_INF   = 12'd2550;
  localparam logic [6:0]  KH_MAX        = 7'd120;
  localparam logic [10:0] PCT_DIV_MUL   = 11'd1311;
  localparam int          PCT_DIV_SHIFT = 17;
  localparam int          LVL_SHIFT     = 8;

  // Reset values
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_SETPT = 32'h0000_01f4;
  localparam logic [31:0] RST_TEMP  = 32'h0a78_6e64;
  localparam logic [31:0] RST_EMG   = 32'h0000_00ff;
  localparam logic [31:0] RST_CORA  = 32'h000c_aafe;
  localparam logic [31:0] RST_CORB  = 32'h0070_8000;
  localparam logic [31:0] RST_ACT   = 32'h0000_0037;
  localparam logic [31:0] RST_PROF  = 32'h0000_0064;
  localparam logic [15:0] PHYS_MIN_MA = 16'h000a;

  typedef enum {CR_TD, CR_NORMAL, CR_DELAY, CR_FADE, CR_BACK, CR_OFF} corridor_e;

  // Fade time code to whole seconds
  function automatic logic [6:0] fade_secs(input logic [3:0] code);
    logic [6:0] s;
    s = 7'd0;
    case (code)
      4'h0: s = 7'd0;   4'h1: s = 7'd1;   4'h2: s = 7'd1;   4'h3: s = 7'd1;
      4'h4: s = 7'd2;   4'h5: s = 7'd3;   4'h6: s = 7'd4;   4'h7: s = 7'd6;
      4'h8: s = 7'd8;   4'h9: s = 7'd11;  4'ha: s = 7'd16;  4'hb: s = 7'd23;
      4'hc: s = 7'd32;  4'hd: s = 7'd45;  4'he: s = 7'd64;  default: s = 7'd91;
    endcase
    return s;
  endfunction : fade_secs

endpackage : led_cfg_pkg

// ### testbench/led_level_ctrl_monitor.sv
/*
  Checker for led_level_ctrl: register port handshakes and corridor entry.
  Assumes it sees only the top ports and is attached by the bind below.
*/
`timescale 1ns/100ps
module led_level_ctrl_monitor
#(
  parameter int TICK_CYCLES = 8
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        mains_cycle,
  input wire logic        ctrl_mains_in,
  input wire logic        dali_mode,
  input wire logic        phys_min,
  input wire logic        corridor_active
);
  int hi_r;
  int lo_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // High cycles on the control input, summed across lows of up to 8 cycles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hi_r <= 0;
      lo_r <= 0;
    end
    else if (ctrl_mains_in)
    begin
      hi_r <= hi_r + 1;
      lo_r <= 0;
    end
    else if (lo_r < 8)
      lo_r <= lo_r + 1;
    else
      hi_r <= 0;
  end

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer latency wrong");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer latency wrong");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy) else $error("write taken while answer pending");
  property p_rbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while answer pending");
  property p_drop;
    mains_cycle |=> !corridor_active;
  endproperty
  a_drop: assert property (p_drop) else $error("corridor kept over power cycle");
  property p_dali;
    $rose(corridor_active) |-> !$past(dali_mode);
  endproperty
  a_dali: assert property (p_dali) else $error("corridor entered outside dim mode");
  property p_act;
    $rose(corridor_active) |-> hi_r >= TICK_CYCLES;
  endproperty
  a_act: assert property (p_act) else $error("corridor entered on short pulse");

  // Main scenarios reached
  c_corr: cover property ($rose(corridor_active));
  c_pmin: cover property ($rose(phys_min));
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule : led_level_ctrl_monitor

bind led_level_ctrl led_level_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_inst (.*);

// ### testbench/presence_switch_model.sv
/*
  Push switch / presence sensor putting mains on the control input.
  Assumes start is a one-cycle request and len counts clock cycles.
*/
`timescale 1ns/100ps
module presence_switch_model
(
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] len,
  output logic             ctrl_mains_in
);
  int left_r = 0;

  // Mains held on the input for the whole pulse, off otherwise
  always_ff @(posedge clk)
  begin
    if (start)
      left_r <= int'(len);
    else if (left_r > 0)
      left_r <= left_r - 1;
  end
  assign ctrl_mains_in = (left_r > 0);
endmodule : presence_switch_model

// ### testbench/led_level_ctrl_bench.sv
/*
  Self-checking bench for led_level_ctrl with a presence switch model.
  Assumes an 8-cycle tick, so one second lasts eight clocks.
*/
`timescale 1ns/100ps
module led_level_ctrl_bench;
  import led_cfg_pkg::*;
  localparam int TK = 8;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_s;
  logic        clk, rst, mains_cycle, lamp_on, ctrl_mains_in, dc_mains_in;
  logic        dali_mode, dali_override, phys_min, output_off, corridor_active;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, module_temp, dim_level;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] current_target, sw_len;
  logic        sw_start;
  int          n_mismatch, num_checks;
  row_s        rows [10] = '{'{8'h00, RST_CTRL, 2'b00}, '{8'h04, RST_SETPT, 2'b00},
    '{8'h08, RST_TEMP, 2'b00}, '{8'h0c, RST_EMG, 2'b00}, '{8'h10, RST_CORA, 2'b00},
    '{8'h14, RST_CORB, 2'b00}, '{8'h18, RST_ACT, 2'b00}, '{8'h20, RST_PROF, 2'b00},
    '{8'h80, 32'h0, 2'b10}, '{8'hfc, 32'h0, 2'b10}};

  led_level_ctrl #(.TICK_CYCLES(TK)) led_level_ctrl_inst (.*);
  presence_switch_model presence_switch_model_inst (.clk(clk), .start(sw_start),
    .len(sw_len), .ctrl_mains_in(ctrl_mains_in));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  task automatic cur(input logic [15:0] e);
    chk_val("current_target", {16'h0, e}, {16'h0, current_target});
  endtask : cur

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // One register transfer; write when wr, read otherwise; ready follows the answer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_arvalid <= !wr;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    chk_bit("bus answer", 1'b1, n == (wr ? 3 : 2));
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    @(posedge clk);
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : bus

  task automatic mains();
    @(posedge clk);
    mains_cycle <= 1'b1;
    @(posedge clk);
    mains_cycle <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : mains

  task automatic press(input logic [15:0] n);
    @(posedge clk);
    sw_start <= 1'b1;
    sw_len   <= n;
    @(posedge clk);
    sw_start <= 1'b0;
  endtask : press

  task automatic drive_temp(input logic [7:0] t);
    @(posedge clk);
    module_temp <= t;
    repeat (4) @(posedge clk);
  endtask : drive_temp

  task automatic wait_cur(input logic [15:0] e);
    int n;
    n = 0;
    while (current_target !== e && n < 300)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_cur

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    int n;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {mains_cycle, dc_mains_in, dali_mode, dali_override, sw_start} = 5'h0;
    lamp_on = 1'b1;
    module_temp = 8'h19;
    dim_level = 8'hfe;
    sw_len = 16'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    cur(16'd500);
    chk_bit("output_off", 1'b0, output_off);
    foreach (rows[i])
    begin
      bus(1'b0, rows[i].a, 32'h0);
      chk_val("read data", rows[i].d, rd);
      chk_val("read resp", {30'h0, rows[i].r}, {30'h0, rs});
    end
    bus(1'b1, 8'hfc, 32'h1);
    chk_val("write resp", 32'h2, {30'h0, rs});
    $display("register table done");
    // Apply on power cycle or, with bit 4 set, lamp off-then-on; setpoint only when enabled
    bus(1'b1, 8'h04, 32'h320);
    mains();
    cur(16'd500);
    bus(1'b1, 8'h00, 32'h1);
    repeat (6) @(posedge clk);
    cur(16'd500);
    mains();
    cur(16'd800);
    bus(1'b1, 8'h00, 32'h11);
    mains();
    bus(1'b1, 8'h04, 32'h258);
    @(posedge clk);
    lamp_on <= 1'b0;
    repeat (4) @(posedge clk);
    lamp_on <= 1'b1;
    repeat (4) @(posedge clk);
    cur(16'd600);
    $display("apply test done");
    // Compensation profile
    bus(1'b1, 8'h38, 32'h46);
    bus(1'b1, 8'h3c, 32'h7832);
    bus(1'b1, 8'h00, 32'h13);
    mains();
    cur(16'd420);
    bus(1'b1, 8'h38, 32'h0);
    mains();
    chk_bit("output_off", 1'b1, output_off);
    bus(1'b1, 8'h38, 32'h64);
    mains();
    cur(16'd600);
    $display("compensation test done");
    // Temperature derating, live parameters
    drive_temp(8'd100);
    cur(16'd600);
    drive_temp(8'd110);
    cur(16'd60);
    bus(1'b1, 8'h08, 32'h1478_6e64);
    repeat (3) @(posedge clk);
    cur(16'd120);
    drive_temp(8'd120);
    chk_bit("phys_min", 1'b1, phys_min);
    drive_temp(8'h19);
    chk_bit("phys_min", 1'b0, phys_min);
    cur(16'd600);
    $display("temperature test done");
    // Emergency dimming on DC
    bus(1'b1, 8'h00, 32'h17);
    mains();
    dc_mains_in <= 1'b1;
    repeat (10) @(posedge clk);
    cur(16'd600);
    bus(1'b1, 8'h0c, 32'h80);
    mains();
    cur(16'd300);
    dali_override <= 1'b1;
    repeat (4) @(posedge clk);
    cur(16'd300);
    bus(1'b1, 8'h00, 32'h1f);
    mains();
    cur(16'd600);
    dc_mains_in <= 1'b0;
    dali_override <= 1'b0;
    $display("emergency test done");
    // Corridor mode
    bus(1'b1, 8'h10, 32'h0004_aafe);
    bus(1'b1, 8'h14, 32'h0000_2001);
    bus(1'b1, 8'h18, 32'h2);
    mains();
    dali_mode <= 1'b1;
    press(16'd40);
    repeat (50) @(posedge clk);
    chk_bit("corridor_active", 1'b0, corridor_active);
    dali_mode <= 1'b0;
    press(16'd6);
    repeat (20) @(posedge clk);
    chk_bit("corridor_active", 1'b0, corridor_active);
    press(16'd80);
    n = 0;
    while (corridor_active !== 1'b1 && n < 70)
    begin
      @(posedge clk);
      n++;
    end
    chk_bit("corridor_active", 1'b1, corridor_active);
    repeat (2) @(posedge clk);
    cur(16'd600);
    wait_cur(16'd496);
    cur(16'd496);
    wait_cur(16'd398);
    cur(16'd398);
    chk_bit("output_off", 1'b0, output_off);
    repeat (40) @(posedge clk);
    chk_bit("output_off", 1'b1, output_off);
    press(16'd20);
    repeat (12) @(posedge clk);
    cur(16'd600);
    mains();
    chk_bit("corridor_active", 1'b0, corridor_active);
    $display("corridor test done");
    give_verdict();
  end
endmodule : led_level_ctrl_bench
